// ### verilog/ouhs_params.svh
`ifndef OUHS_PARAMS_SVH
`define OUHS_PARAMS_SVH

`define OUHS_NCH            8
// Channel register offsets (address bits 3:0)
`define OUHS_CH_MCR         4'h4
`define OUHS_CH_MSR         4'h6
`define OUHS_CH_FEATURE_CONTROL_REG        4'h8
`define OUHS_CH_RXLVL       4'hF
`define OUHS_MCR_DTR        0
`define OUHS_MCR_RTS        1
`define OUHS_MCR_IR         6
`define OUHS_FEATURE_CONTROL_REG_IRINV     4
// Configuration space offsets (address bit 7 set)
`define OUHS_CFG_TMR_LO     4'h0
`define OUHS_CFG_TMR_HI     4'h1
`define OUHS_CFG_RESET      4'h3
`define OUHS_CFG_BCAST      4'h4
`define OUHS_BCAST_BIT      0
`define OUHS_SPACE_BIT      7
`define OUHS_REG_RST_VAL    8'h00
// Host APB register map
`define OUHS_APB_CTRL       12'h000
`define OUHS_APB_ADDR       12'h004
`define OUHS_APB_WDATA      12'h008
`define OUHS_APB_RDATA      12'h00C
`define OUHS_APB_STAT       12'h010
`define OUHS_CTRL_GO        0
`define OUHS_CTRL_WR        1
`define OUHS_CTRL_HWRST     2
`define OUHS_CTRL_BUSSEL    3
`define OUHS_STAT_BUSY      0
`define OUHS_STAT_DONE      1
// Timing
`define OUHS_CLK_PERIOD_NS  100
`define OUHS_RST_MIN_NS     40
`define OUHS_RST_CYC        ((`OUHS_RST_MIN_NS + `OUHS_CLK_PERIOD_NS - 1) / `OUHS_CLK_PERIOD_NS)
`define OUHS_SETUP_CYC      3
`define OUHS_STROBE_CYC     8

`endif

// ### verilog/ouhs_pkg.sv
package ouhs_pkg;
  typedef logic [2:0] ouhs_chan_t;
  typedef logic [3:0] ouhs_cnt_t;
  typedef enum logic [2:0]
  {
    OUHS_IDLE   = 3'b000,
    OUHS_SETUP  = 3'b001,
    OUHS_STROBE = 3'b010,
    OUHS_HOLD   = 3'b011,
    OUHS_RESET  = 3'b100
  } ouhs_hstate_t;
endpackage

// ### verilog/ouhs_bus_if.sv
interface ouhs_bus_if;
  logic [7:0] addr;
  logic       cs_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       bus_select;
  logic       rst_n;
  logic [7:0] host_dout;
  logic       host_doe_n;
  logic [7:0] dev_dout;
  logic       dev_doe_n;
  logic [7:0] data;

  // Undriven bus reads as pulled up
  assign data = !dev_doe_n ? dev_dout : (!host_doe_n ? host_dout : 8'hFF);

  modport host
  (
    output addr,
    output cs_n,
    output read_strobe_n,
    output write_strobe_n,
    output bus_select,
    output rst_n,
    output host_dout,
    output host_doe_n,
    input  data
  );

  modport dev
  (
    input  addr,
    input  cs_n,
    input  read_strobe_n,
    input  write_strobe_n,
    input  bus_select,
    input  rst_n,
    output dev_dout,
    output dev_doe_n,
    input  data
  );
endinterface

// ### verilog/ouhs_device.sv
// Operation
// - RX idles high; control bit inverts infrared
// - Strap sampled at every reset into infrared
// - Host must drive reset at power-up
// - Bus-select pin picks separate or single strobe
// - Hardware reset restores all eight channels
// - Reset low longer than forty nanoseconds
// - Reset register write resets chosen channels
// - Channel access only with chip select low
// - Address bits six to four pick channel
// - Broadcast bit writes all eight channels together
// - Host avoids broadcast mode changes mid-traffic
// - External clock drives sixteen-bit timer counter
// - Modem pins double as general purpose
//
// The APB slave port and the placing of the registers were decided locally.
`include "ouhs_params.svh"

module ouhs_device
(
  input  wire logic       REF_CLK,
  input  wire logic       NRST,
  ouhs_bus_if.dev         BUS,
  input  wire logic [7:0] RX,
  input  wire logic [7:0] CTS_N,
  input  wire logic [7:0] DSR_N,
  input  wire logic [7:0] CD_N,
  input  wire logic [7:0] RI_N,
  input  wire logic       INFRARED_ENABLE_STRAP,
  input  wire logic       TIMER_EXT_CLOCK,
  input  wire logic       OSC_IN,
  output logic      [7:0] TX,
  output logic      [7:0] RTS_N,
  output logic      [7:0] DTR_N,
  output logic            OSC_OUT
);

  logic [63:0] raw_in;
  logic [63:0] sync1_ff;
  logic [63:0] sync2_ff;
  logic [7:0]  addr;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic        bus_sel;
  logic        pin_rst_n;
  logic [7:0]  din;
  logic        strap;
  logic        tmr_clk;
  logic        osc;
  logic [7:0]  ri_n;
  logic [7:0]  cd_n;
  logic [7:0]  dsr_n;
  logic [7:0]  cts_n;
  logic [7:0]  rx;
  logic        hw_rst;
  logic        sel;
  logic        rd_act;
  logic        wr_act;
  logic        wr_act_ff;
  logic        wr_pulse;
  logic        cfg_space;
  logic [2:0]  chan;
  logic [3:0]  off;
  logic        cfg_wr;
  logic [7:0]  soft_rst;
  logic [7:0]  ch_wr;
  logic [7:0]  chan_rd [8];
  logic        bcast_ff;
  logic        tmr_ff;
  logic [15:0] tmr_cnt_ff;
  logic [7:0]  rd_data;
  logic [7:0]  dout_ff;
  logic        doe_n_ff;
  logic        osc_ff;

  // Every pin except REF_CLK and NRST is asynchronous to REF_CLK, so all of those go through two stages
  assign raw_in = {RX, CTS_N, DSR_N, CD_N, RI_N, OSC_IN, TIMER_EXT_CLOCK,
                   INFRARED_ENABLE_STRAP, BUS.data, BUS.rst_n, BUS.bus_select,
                   BUS.write_strobe_n, BUS.read_strobe_n, BUS.cs_n, BUS.addr};

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      sync1_ff <= 64'h0000_0000_0000_0000;
      sync2_ff <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  assign addr      = sync2_ff[7:0];
  assign cs_n      = sync2_ff[8];
  assign rd_n      = sync2_ff[9];
  assign wr_n      = sync2_ff[10];
  assign bus_sel   = sync2_ff[11];
  assign pin_rst_n = sync2_ff[12];
  assign din       = sync2_ff[20:13];
  assign strap     = sync2_ff[21];
  assign tmr_clk   = sync2_ff[22];
  assign osc       = sync2_ff[23];
  assign ri_n      = sync2_ff[31:24];
  assign cd_n      = sync2_ff[39:32];
  assign dsr_n     = sync2_ff[47:40];
  assign cts_n     = sync2_ff[55:48];
  assign rx        = sync2_ff[63:56];

  // full reset source
  // Any low seen for one clock counts; the pin has no filter
  assign hw_rst = !NRST || !pin_rst_n;

  assign sel = !cs_n;

  // strobe style decode
  // Single-strobe style: write strobe pin carries direction, high reads
  assign rd_act = sel && (bus_sel ? !rd_n : wr_n);
  assign wr_act = sel && !wr_n;

  always_ff @(posedge REF_CLK)
  begin
    if (hw_rst)
      wr_act_ff <= 1'b0;
    else
      wr_act_ff <= wr_act;
  end

  assign wr_pulse = wr_act && !wr_act_ff;

  assign cfg_space = addr[`OUHS_SPACE_BIT];
  assign chan      = addr[6:4];
  assign off       = addr[3:0];
  assign cfg_wr    = wr_pulse && cfg_space;

  assign soft_rst = (cfg_wr && off == `OUHS_CFG_RESET) ? din : 8'h00;

  always_comb
  begin
    for (int i = 0; i < `OUHS_NCH; i++)
      ch_wr[i] = wr_pulse && !cfg_space && (bcast_ff || chan == i[2:0]);
  end

  generate
    for (genvar g = 0; g < `OUHS_NCH; g++)
    begin : gen_ch
      logic [7:0] regs_ff [16];
      logic       tx_ff;
      logic       rts_n_ff;
      logic       dtr_n_ff;
      logic       rx_lvl;

      always_ff @(posedge REF_CLK)
      begin
        if (hw_rst || soft_rst[g])
        begin
          for (int k = 0; k < 16; k++)
            regs_ff[k] <= `OUHS_REG_RST_VAL;
          regs_ff[`OUHS_CH_MCR][`OUHS_MCR_IR] <= strap;
        end
        else if (ch_wr[g] && off != `OUHS_CH_MSR && off != `OUHS_CH_RXLVL)
          regs_ff[off] <= din;
      end

      always_ff @(posedge REF_CLK)
      begin
        if (hw_rst || soft_rst[g])
        begin
          rts_n_ff <= 1'b1;
          dtr_n_ff <= 1'b1;
          tx_ff    <= 1'b1;
        end
        else
        begin
          rts_n_ff <= !regs_ff[`OUHS_CH_MCR][`OUHS_MCR_RTS];
          dtr_n_ff <= !regs_ff[`OUHS_CH_MCR][`OUHS_MCR_DTR];
          // Infrared transmit idles low, normal line idles high
          tx_ff    <= !regs_ff[`OUHS_CH_MCR][`OUHS_MCR_IR];
        end
      end

      assign rx_lvl = regs_ff[`OUHS_CH_FEATURE_CONTROL_REG][`OUHS_FEATURE_CONTROL_REG_IRINV] ? !rx[g] : rx[g];

      assign chan_rd[g] = (off == `OUHS_CH_MSR)   ? {!cd_n[g], !ri_n[g], !dsr_n[g],
                                                    !cts_n[g], 4'h0} :
                          (off == `OUHS_CH_RXLVL) ? {7'h00, rx_lvl} : regs_ff[off];

      assign TX[g]    = tx_ff;
      assign RTS_N[g] = rts_n_ff;
      assign DTR_N[g] = dtr_n_ff;
    end
  endgenerate

  always_ff @(posedge REF_CLK)
  begin
    if (hw_rst)
      bcast_ff <= 1'b0;
    else if (cfg_wr && off == `OUHS_CFG_BCAST)
      bcast_ff <= din[`OUHS_BCAST_BIT];
  end

  // timer counts external clock rising edges
  // Sampled, so the external clock must stay below half of REF_CLK
  always_ff @(posedge REF_CLK)
  begin
    if (hw_rst)
    begin
      tmr_ff     <= 1'b0;
      tmr_cnt_ff <= 16'h0000;
    end
    else
    begin
      tmr_ff <= tmr_clk;
      if (cfg_wr && off == `OUHS_CFG_TMR_LO)
        tmr_cnt_ff <= 16'h0000;
      else if (tmr_clk && !tmr_ff)
        tmr_cnt_ff <= tmr_cnt_ff + 16'h0001;
    end
  end

  always_comb
  begin
    rd_data = 8'h00;
    if (cfg_space)
    begin
      case (off)
        `OUHS_CFG_TMR_LO: rd_data = tmr_cnt_ff[7:0];
        `OUHS_CFG_TMR_HI: rd_data = tmr_cnt_ff[15:8];
        `OUHS_CFG_BCAST:  rd_data = {7'h00, bcast_ff};
        default:          rd_data = 8'h00;
      endcase
    end
    else
      rd_data = chan_rd[chan];
  end

  always_ff @(posedge REF_CLK)
  begin
    if (hw_rst)
    begin
      dout_ff  <= 8'h00;
      doe_n_ff <= 1'b1;
    end
    else
    begin
      dout_ff  <= rd_data;
      doe_n_ff <= !rd_act;
    end
  end

  // Coarse sampled inverted copy of OSC_IN; a real crystal output is analog
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      osc_ff <= 1'b0;
    else
      osc_ff <= !osc;
  end

  assign BUS.dev_dout  = dout_ff;
  assign BUS.dev_doe_n = doe_n_ff;
  assign OSC_OUT       = osc_ff;

endmodule

// ### verilog/ouhs_host.sv
`include "ouhs_params.svh"

module ouhs_host
(
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  ouhs_bus_if.host         BUS,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  ouhs_pkg::ouhs_hstate_t state_ff;
  ouhs_pkg::ouhs_cnt_t    cnt_ff;
  logic [7:0]  d_sync1_ff;
  logic [7:0]  d_sync2_ff;
  logic [3:0]  ctrl_ff;
  logic [7:0]  addr_ff;
  logic [7:0]  wdata_ff;
  logic [7:0]  rdata_ff;
  logic        done_ff;
  logic        start_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        acc;
  logic        xfer_end;
  logic        mapped;
  logic [31:0] rd_mux;
  logic        cs_n_ff;
  logic        rd_n_ff;
  logic        wr_n_ff;
  logic        rst_n_ff;
  logic        doe_n_ff;

  assign acc      = PSEL && PENABLE && pready_ff;
  assign xfer_end = state_ff == ouhs_pkg::OUHS_HOLD && cnt_ff == 4'h0;
  assign mapped   = PADDR == `OUHS_APB_CTRL || PADDR == `OUHS_APB_ADDR ||
                    PADDR == `OUHS_APB_WDATA || PADDR == `OUHS_APB_RDATA ||
                    PADDR == `OUHS_APB_STAT;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `OUHS_APB_CTRL:  rd_mux = {28'h000_0000, ctrl_ff};
      `OUHS_APB_ADDR:  rd_mux = {24'h00_0000, addr_ff};
      `OUHS_APB_WDATA: rd_mux = {24'h00_0000, wdata_ff};
      `OUHS_APB_RDATA: rd_mux = {24'h00_0000, rdata_ff};
      `OUHS_APB_STAT:  rd_mux = {30'h0000_0000, done_ff,
                                 state_ff != ouhs_pkg::OUHS_IDLE};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait-free answer: ready in the first access cycle
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= PSEL && !PENABLE;
      pslverr_ff <= PSEL && !PENABLE && !mapped;
      prdata_ff  <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      ctrl_ff  <= 4'h0;
      addr_ff  <= 8'h00;
      wdata_ff <= 8'h00;
      start_ff <= 1'b0;
      done_ff  <= 1'b0;
    end
    else
    begin
      start_ff <= 1'b0;
      if (acc && PWRITE && PADDR == `OUHS_APB_CTRL && state_ff == ouhs_pkg::OUHS_IDLE)
      begin
        ctrl_ff  <= PWDATA[3:0];
        start_ff <= PWDATA[`OUHS_CTRL_GO] || PWDATA[`OUHS_CTRL_HWRST];
      end
      if (acc && PWRITE && PADDR == `OUHS_APB_ADDR)
        addr_ff <= PWDATA[7:0];
      if (acc && PWRITE && PADDR == `OUHS_APB_WDATA)
        wdata_ff <= PWDATA[7:0];
      // Completion beats a clear in the same cycle
      if (xfer_end)
        done_ff <= 1'b1;
      else if (acc && PWRITE && PADDR == `OUHS_APB_STAT && PWDATA[`OUHS_STAT_DONE])
        done_ff <= 1'b0;
    end
  end

  // Device drives data asynchronously to this clock
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      d_sync1_ff <= 8'h00;
      d_sync2_ff <= 8'h00;
      rdata_ff   <= 8'h00;
    end
    else
    begin
      d_sync1_ff <= BUS.data;
      d_sync2_ff <= d_sync1_ff;
      if (state_ff == ouhs_pkg::OUHS_STROBE && cnt_ff == 4'h0 && !ctrl_ff[`OUHS_CTRL_WR])
        rdata_ff <= d_sync2_ff;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      state_ff <= ouhs_pkg::OUHS_RESET;
      cnt_ff   <= 4'(`OUHS_RST_CYC - 1);
    end
    else
    begin
      if (cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
      case (state_ff)
        ouhs_pkg::OUHS_IDLE:
          if (start_ff && ctrl_ff[`OUHS_CTRL_HWRST])
          begin
            state_ff <= ouhs_pkg::OUHS_RESET;
            cnt_ff   <= 4'(`OUHS_RST_CYC - 1);
          end
          else if (start_ff)
          begin
            state_ff <= ouhs_pkg::OUHS_SETUP;
            cnt_ff   <= 4'(`OUHS_SETUP_CYC - 1);
          end
        ouhs_pkg::OUHS_SETUP:
          if (cnt_ff == 4'h0)
          begin
            state_ff <= ouhs_pkg::OUHS_STROBE;
            cnt_ff   <= 4'(`OUHS_STROBE_CYC - 1);
          end
        ouhs_pkg::OUHS_STROBE:
          if (cnt_ff == 4'h0)
          begin
            state_ff <= ouhs_pkg::OUHS_HOLD;
            cnt_ff   <= 4'(`OUHS_SETUP_CYC - 1);
          end
        ouhs_pkg::OUHS_HOLD:
          if (cnt_ff == 4'h0)
            state_ff <= ouhs_pkg::OUHS_IDLE;
        ouhs_pkg::OUHS_RESET:
          if (cnt_ff == 4'h0)
            state_ff <= ouhs_pkg::OUHS_IDLE;
        default:
          state_ff <= ouhs_pkg::OUHS_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      cs_n_ff  <= 1'b1;
      rd_n_ff  <= 1'b1;
      wr_n_ff  <= 1'b1;
      rst_n_ff <= 1'b0;
      doe_n_ff <= 1'b1;
    end
    else
    begin
      rst_n_ff <= !(state_ff == ouhs_pkg::OUHS_RESET && cnt_ff != 4'h0) &&
                  !(state_ff == ouhs_pkg::OUHS_IDLE && start_ff && ctrl_ff[`OUHS_CTRL_HWRST]);
      rd_n_ff  <= 1'b1;
      wr_n_ff  <= 1'b1;
      cs_n_ff  <= 1'b1;
      doe_n_ff <= 1'b1;
      // Select and direction span the strobe's last cycle, so they never blink before hold
      if (state_ff == ouhs_pkg::OUHS_IDLE && start_ff && !ctrl_ff[`OUHS_CTRL_HWRST] ||
          state_ff == ouhs_pkg::OUHS_SETUP ||
          state_ff == ouhs_pkg::OUHS_STROBE ||
          state_ff == ouhs_pkg::OUHS_HOLD && cnt_ff != 4'h0)
      begin
        doe_n_ff <= !ctrl_ff[`OUHS_CTRL_WR];
        if (ctrl_ff[`OUHS_CTRL_BUSSEL])
          cs_n_ff <= 1'b0;
        else
          wr_n_ff <= !ctrl_ff[`OUHS_CTRL_WR];
      end
      if (state_ff == ouhs_pkg::OUHS_SETUP && cnt_ff == 4'h0 ||
          state_ff == ouhs_pkg::OUHS_STROBE && cnt_ff != 4'h0)
      begin
        if (ctrl_ff[`OUHS_CTRL_BUSSEL])
        begin
          rd_n_ff <= ctrl_ff[`OUHS_CTRL_WR];
          wr_n_ff <= !ctrl_ff[`OUHS_CTRL_WR];
        end
        else
          cs_n_ff <= 1'b0;
      end
    end
  end

  assign BUS.addr           = addr_ff;
  assign BUS.cs_n           = cs_n_ff;
  assign BUS.read_strobe_n  = rd_n_ff;
  assign BUS.write_strobe_n = wr_n_ff;
  assign BUS.bus_select     = ctrl_ff[`OUHS_CTRL_BUSSEL];
  assign BUS.rst_n          = rst_n_ff;
  assign BUS.host_dout      = wdata_ff;
  assign BUS.host_doe_n     = doe_n_ff;
  assign PRDATA             = prdata_ff;
  assign PREADY             = pready_ff;
  assign PSLVERR            = pslverr_ff;

endmodule

// ### testbench/ouhs_checker.sv
module ouhs_checker
(
  input wire logic       REF_CLK,
  input wire logic       NRST,
  input wire logic [7:0] addr,
  input wire logic       cs_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       bus_select,
  input wire logic       rst_n,
  input wire logic       host_doe_n,
  input wire logic       dev_doe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic rd_act;

  // Read condition as seen on the pins, either bus style
  assign rd_act = rst_n && !cs_n && (bus_select ? !read_strobe_n : write_strobe_n);

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  a_read_needs_select: assert property (
    !dev_doe_n |-> $past(!cs_n, 3))
    else $error("device drove the bus without chip select");
  a_read_style_pins: assert property (
    !dev_doe_n |-> $past(bus_select ? !read_strobe_n : write_strobe_n, 3))
    else $error("device drove the bus without a read in the chosen style");
  a_read_answer_time: assert property (
    rd_act [*4] |-> !dev_doe_n)
    else $error("device late to answer a read");
  a_write_in_select: assert property (
    bus_select && !write_strobe_n |-> !cs_n && !host_doe_n)
    else $error("write strobe outside chip select");
  a_wstrobe_width: assert property (
    $fell(write_strobe_n) && bus_select |-> !write_strobe_n [*8] ##1 write_strobe_n)
    else $error("separate write strobe width wrong");
  a_cs_strobe_width: assert property (
    $fell(cs_n) && !bus_select |-> !cs_n [*8] ##1 cs_n)
    else $error("single strobe width wrong");
  a_setup_before_strobe: assert property (
    $fell(write_strobe_n) && bus_select |-> $past(!cs_n, 3) && $past(!host_doe_n, 3))
    else $error("write strobe without setup");
  a_hold_after_strobe: assert property (
    $rose(write_strobe_n) && bus_select |-> !cs_n [*3] ##1 cs_n)
    else $error("chip select not held through write hold");
  a_addr_steady: assert property (
    !cs_n && $past(!cs_n) |-> $stable(addr))
    else $error("address moved during access");
  a_idle_in_reset: assert property (
    !rst_n |-> cs_n && dev_doe_n)
    else $error("bus active during device reset");

  cover property (bus_select && $fell(write_strobe_n));
  cover property (!bus_select && $fell(cs_n) && !write_strobe_n);
  cover property ($fell(dev_doe_n) && bus_select);
  cover property ($fell(dev_doe_n) && !bus_select);
  cover property ($fell(rst_n));
endmodule

// ### testbench/octal_uart_host_select_bench.sv
`include "ouhs_params.svh"

module octal_uart_host_select_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  rx      = 8'hFF;
  logic [7:0]  cts_n   = 8'hFF;
  logic [7:0]  dsr_n   = 8'hFF;
  logic [7:0]  cd_n    = 8'hFF;
  logic [7:0]  ri_n    = 8'hFF;
  logic        strap   = 1'b0;
  logic        tmr     = 1'b0;
  logic        osc_in  = 1'b0;
  logic [7:0]  tx;
  logic [7:0]  rts_n;
  logic [7:0]  dtr_n;
  logic        osc_out;
  logic [31:0] rdat;
  logic        serr;
  logic [7:0]  m;
  int          err_total = 0;
  int          cmp_count = 0;

  always #50 ref_clk = ~ref_clk;

  ouhs_bus_if u_ouhs_bus_if ();

  ouhs_host u_ouhs_host (.REF_CLK(ref_clk), .NRST(nrst), .BUS(u_ouhs_bus_if), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));

  ouhs_device u_ouhs_device (.REF_CLK(ref_clk), .NRST(nrst), .BUS(u_ouhs_bus_if), .RX(rx),
    .CTS_N(cts_n), .DSR_N(dsr_n), .CD_N(cd_n), .RI_N(ri_n), .INFRARED_ENABLE_STRAP(strap),
    .TIMER_EXT_CLOCK(tmr), .OSC_IN(osc_in), .TX(tx), .RTS_N(rts_n), .DTR_N(dtr_n),
    .OSC_OUT(osc_out));

  ouhs_checker u_ouhs_checker (.REF_CLK(ref_clk), .NRST(nrst), .addr(u_ouhs_bus_if.addr),
    .cs_n(u_ouhs_bus_if.cs_n), .read_strobe_n(u_ouhs_bus_if.read_strobe_n),
    .write_strobe_n(u_ouhs_bus_if.write_strobe_n), .bus_select(u_ouhs_bus_if.bus_select),
    .rst_n(u_ouhs_bus_if.rst_n), .host_doe_n(u_ouhs_bus_if.host_doe_n),
    .dev_doe_n(u_ouhs_bus_if.dev_doe_n));

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge behind
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      stop_test();
    end
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Waits for status bit b to read v; a reset op never sets done
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `OUHS_APB_STAT, 32'h0000_0000);
      n++;
    end
    while (rdat[b] !== v && n < 40);
    if (n >= 40)
    begin
      err_total++;
      stop_test();
    end
    apb(1'b1, `OUHS_APB_STAT, 32'h0000_0002);
  endtask

  // One device bus cycle; sep picks the separate-strobe style
  task automatic dev(input logic w, input logic sep, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, `OUHS_APB_ADDR, 32'(a));
    apb(1'b1, `OUHS_APB_WDATA, 32'(d));
    apb(1'b1, `OUHS_APB_CTRL, 32'({sep, 1'b0, w, 1'b1}));
    poll(`OUHS_STAT_DONE, 1'b1);
    apb(1'b0, `OUHS_APB_RDATA, 32'h0000_0000);
  endtask

  task automatic dchk(input logic sep, input logic [7:0] a, input logic [7:0] e);
    dev(1'b0, sep, a, 8'h00);
    check($sformatf("reg_%h", a), {24'h00_0000, rdat[7:0]}, 32'(e));
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check("tx", tx, 8'hFF);
    check("rts_n", rts_n, 8'hFF);
    check("osc_out", osc_out, 1'b1);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check("slverr", serr, 1'b1);
    check("unmapped", rdat, 32'h0000_0000);
    // each channel by address, styles alternating
    for (int c = 0; c < 8; c++)
    begin
      m = 8'hFF << (c + 1);
      dev(1'b1, c[0], {1'b0, c[2:0], `OUHS_CH_MCR}, 8'h03);
      check("rts_n", rts_n, m);
      check("dtr_n", dtr_n, m);
      dchk(~c[0], {1'b0, c[2:0], `OUHS_CH_MCR}, 8'h03);
    end
    // broadcast only while no serial traffic runs
    dev(1'b1, 1'b1, 8'hC4, 8'h01);
    dchk(1'b0, 8'h44, 8'h03);
    dchk(1'b1, 8'h84, 8'h01);
    dev(1'b1, 1'b0, 8'h24, 8'h01);
    check("rts_n", rts_n, 8'hFF);
    check("dtr_n", dtr_n, 8'h00);
    dev(1'b1, 1'b1, 8'h84, 8'h00);
    dev(1'b1, 1'b1, 8'h54, 8'h00);
    check("dtr_n", dtr_n, 8'h20);
    // soft reset of channels 0 and 2
    strap <= 1'b1;
    dev(1'b1, 1'b0, 8'h83, 8'h05);
    check("tx", tx, 8'hFA);
    check("dtr_n", dtr_n, 8'h25);
    dchk(1'b0, 8'h04, 8'h40);
    dchk(1'b1, 8'h3F, 8'h01);
    dev(1'b1, 1'b1, 8'h38, 8'h10);
    dchk(1'b0, 8'h3F, 8'h00);
    rx[3] <= 1'b0;
    dchk(1'b0, 8'h3F, 8'h01);
    // modem inputs read as general inputs
    cts_n[6] <= 1'b0;
    dsr_n[6] <= 1'b0;
    dchk(1'b1, 8'h66, 8'h30);
    cd_n[6] <= 1'b0;
    ri_n[6]  <= 1'b0;
    dchk(1'b0, 8'h66, 8'hF0);
    dev(1'b1, 1'b1, 8'h80, 8'h00);
    repeat (5)
    begin
      tmr <= 1'b1;
      repeat (4) @(posedge ref_clk);
      tmr <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    dchk(1'b1, 8'h80, 8'h05);
    dchk(1'b0, 8'h81, 8'h00);
    apb(1'b1, `OUHS_APB_CTRL, 32'h0000_0004);
    poll(`OUHS_STAT_BUSY, 1'b0);
    check("tx", tx, 8'h00);
    check("rts_n", rts_n, 8'hFF);
    check("dtr_n", dtr_n, 8'hFF);
    dchk(1'b1, 8'h38, 8'h00);
    dchk(1'b0, 8'h84, 8'h00);
    dchk(1'b1, 8'h80, 8'h00);
    osc_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("osc_out", osc_out, 1'b0);
    stop_test();
  end
endmodule
